// ===== src/scdiv_pkg.sv
package scdiv_pkg;
  // register byte addresses on the plain register port
  localparam logic [7:0] ADDR_TRIM = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_OSC_CFG = 8'h08;
  // divider control register fields
  localparam int UNLOCK_BIT = 7;
  localparam int SEL_W = 4;
  localparam logic [7:0] UNLOCK_ONLY = 8'h80;
  localparam logic [7:0] SEL_FIELD = 8'h0F;
  // reset values and maximum code of divide_select
  localparam logic [3:0] SEL_RESET_PLAIN = 4'h0;
  localparam logic [3:0] SEL_RESET_DIV8 = 4'h3;
  localparam logic [3:0] SEL_MAX = 4'h8;
  // unlock window length in divided clock cycles
  localparam logic [2:0] UNLOCK_CYCLES = 3'h4;
  // ripple counter width, enough for divide by 256
  localparam int CNT_W = 8;
  // oscillator config register bits
  localparam int SRC_RC_BIT = 0;
  localparam int EXT_CLK_BIT = 1;
  // trim range bit position
  localparam int TRIM_RANGE_BIT = 7;
  // neutral factory trim default, arbitrary value
  localparam logic [7:0] TRIM_FACTORY_DEF = 8'h80;
endpackage : scdiv_pkg

// ===== src/scdiv_ripple.sv
`timescale 1ns/1ps
// free running divide counter on the undivided source clock
module scdiv_ripple #(
  parameter int WIDTH = scdiv_pkg::CNT_W
) (
  input wire logic sys_clk_i,            // undivided source clock
  input wire logic reset_i,              // async reset, active high
  output logic [WIDTH-1:0] count_o       // count state, internal only
);
  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;

  // count up; bit k toggles at source / 2^(k+1)
  always_comb
  begin
    next_count = count + WIDTH'(1);
  end

  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
      count <= '0;
    else
      count <= next_count;
  end

  assign count_o = count;
endmodule : scdiv_ripple

// ===== src/scdiv_top.sv
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
// Summary of operation
// - system clock enable follows divide_select
// - switch division only at aligned tick
// - no intermediate rate above old or new
// - new division active at the next tick of the slower code
// - ripple counter on source clock, unreadable
// - unlock sets only with other bits zero
// - unlock clears after four cycles or select
// - repeated unlock neither extends nor clears
// - codes 0..8 divide by 2^code; rest reserved
// - reset select from divide-by-eight fuse
// - any select value accepted at run time
// - factory trim loaded at reset
// - trim bit 7 picks oscillator range
// - trim bits 6..0 tune within range
// - timer oscillator only with RC source
module scdiv_top #(
  parameter logic [7:0] FACTORY_TRIM = scdiv_pkg::TRIM_FACTORY_DEF
) (
  input wire logic sys_clk_i,            // undivided source clock
  input wire logic reset_i,              // chip reset, active high
  input wire logic divide_by_eight_fuse_i, // fuse programmed when high
  input wire logic rc_source_sel_i,      // system runs on internal rc
  input wire logic [7:0] addr_i,         // register byte address
  input wire logic [7:0] wdata_i,        // write data
  input wire logic wr_i,                 // write strobe
  input wire logic rd_i,                 // read strobe
  output logic [7:0] rdata_o,            // read data, cycle after rd_i
  output logic sys_clk_en_o,             // one source cycle per tick
  output logic [3:0] divide_select_o,    // active division code
  output logic [7:0] rc_osc_trim_o,      // trim word to oscillator
  output logic trim_range_bit_o,         // high range when set
  output logic [6:0] trim_fine_o,        // fine tune within range
  output logic timer_osc_enable_o,       // timer osc allowed on pins
  output logic timer_external_clock_select_o // timer takes ext clock
);
  logic [scdiv_pkg::CNT_W-1:0] count;
  logic first_cycle;
  logic next_first_cycle;
  logic [3:0] sel_req;
  logic [3:0] next_sel_req;
  logic [3:0] sel_act;
  logic [3:0] next_sel_act;
  logic unlock;
  logic next_unlock;
  logic [2:0] unlock_cnt;
  logic [2:0] next_unlock_cnt;
  logic [7:0] trim;
  logic [7:0] next_trim;
  logic ext_clk_sel;
  logic next_ext_clk_sel;
  logic [7:0] rdata;
  logic [7:0] next_rdata;
  logic tick_act;
  logic tick_req;
  logic wr_ctrl;

  // true when count is aligned to a period of the given code
  function automatic logic tick_of(input logic [3:0] code,
                                   input logic [scdiv_pkg::CNT_W-1:0] c);
    logic [scdiv_pkg::CNT_W-1:0] mask;
    mask = '0;
    if (code <= scdiv_pkg::SEL_MAX)
      mask = scdiv_pkg::CNT_W'((9'h001 << code) - 9'h001);
    else
      mask = '1; // reserved codes run at the slowest rate
    tick_of = ((c & mask) == mask);
  endfunction : tick_of

  scdiv_ripple #(
    .WIDTH(scdiv_pkg::CNT_W)
  ) u_ripple (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .count_o(count)
  );

  assign tick_act = tick_of(sel_act, count);
  assign tick_req = tick_of(sel_req, count);
  assign wr_ctrl = wr_i && (addr_i == scdiv_pkg::ADDR_CTRL);

  assign sys_clk_en_o = tick_act;
  assign divide_select_o = sel_act;

  // decoded bus events shared by the register groups below
  logic [3:0] strap_sel;
  logic unlock_wr;
  logic sel_wr;
  logic window_end;
  logic trim_wr;
  logic cfg_wr;

  // fuse strap; only looked at while first_cycle is high
  assign strap_sel = divide_by_eight_fuse_i ? scdiv_pkg::SEL_RESET_DIV8
                                            : scdiv_pkg::SEL_RESET_PLAIN;
  assign unlock_wr = wr_ctrl && (wdata_i == scdiv_pkg::UNLOCK_ONLY);
  // select write needs an open window and a clear unlock bit
  assign sel_wr = wr_ctrl && unlock && !wdata_i[scdiv_pkg::UNLOCK_BIT];
  assign window_end = unlock && tick_act
                      && (unlock_cnt == scdiv_pkg::UNLOCK_CYCLES - 3'h1);
  assign trim_wr = wr_i && (addr_i == scdiv_pkg::ADDR_TRIM);
  assign cfg_wr = wr_i && (addr_i == scdiv_pkg::ADDR_OSC_CFG);

  // first cycle after release; strap and factory trim are taken here
  // so that the async reset branches load constants only
  always_comb
  begin
    next_first_cycle = 1'b0;
  end

  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
      first_cycle <= 1'b1;
    else
      first_cycle <= next_first_cycle;
  end

  // unlock window; a stray write cannot open it
  always_comb
  begin
    next_unlock = unlock;
    next_unlock_cnt = unlock_cnt;
    if (unlock && tick_act)
      next_unlock_cnt = unlock_cnt + 3'h1;
    if (window_end)
    begin
      next_unlock = 1'b0;
      next_unlock_cnt = '0;
    end
    if (unlock_wr && !unlock)
    begin
      next_unlock = 1'b1;
      next_unlock_cnt = '0;
    end
    if (sel_wr)
    begin
      next_unlock = 1'b0;
      next_unlock_cnt = '0;
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      unlock <= 1'b0;
      unlock_cnt <= '0;
    end
    else
    begin
      unlock <= next_unlock;
      unlock_cnt <= next_unlock_cnt;
    end
  end

  // requested and active division codes
  always_comb
  begin
    next_sel_req = sel_req;
    next_sel_act = sel_act;
    if (first_cycle)
    begin
      next_sel_req = strap_sel;
      next_sel_act = strap_sel;
    end
    if (sel_wr)
      next_sel_req = wdata_i[scdiv_pkg::SEL_W-1:0];
    // switch when both old and new periods end together
    // so no shortened period appears and the change lands within one
    // old plus at most two new periods
    if (sel_req != sel_act && tick_act && tick_req)
      next_sel_act = sel_req;
  end

  // requested code is held apart from the active one so that a write
  // never cuts the running period short
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      sel_req <= scdiv_pkg::SEL_RESET_PLAIN;
      sel_act <= scdiv_pkg::SEL_RESET_PLAIN;
    end
    else
    begin
      sel_req <= next_sel_req;
      sel_act <= next_sel_act;
    end
  end

  // oscillator trim word; software may retune after reset
  always_comb
  begin
    next_trim = trim;
    if (first_cycle)
      next_trim = FACTORY_TRIM;
    if (trim_wr)
      next_trim = wdata_i;
  end

  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
      trim <= scdiv_pkg::TRIM_FACTORY_DEF;
    else
      trim <= next_trim;
  end

  // timer clock source choice, stored even while gated off
  always_comb
  begin
    next_ext_clk_sel = ext_clk_sel;
    if (cfg_wr)
      next_ext_clk_sel = wdata_i[scdiv_pkg::EXT_CLK_BIT];
  end

  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
      ext_clk_sel <= 1'b0;
    else
      ext_clk_sel <= next_ext_clk_sel;
  end

  // read data; zero outside the cycle after a read strobe
  always_comb
  begin
    next_rdata = '0;
    if (rd_i)
    begin
      unique case (addr_i)
        scdiv_pkg::ADDR_TRIM: next_rdata = trim;
        scdiv_pkg::ADDR_CTRL: next_rdata = {unlock, 3'h0, sel_req};
        scdiv_pkg::ADDR_OSC_CFG:
          next_rdata = {6'h00, ext_clk_sel, rc_source_sel_i};
        default: next_rdata = '0; // unmapped reads return zero
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
      rdata <= '0;
    else
      rdata <= next_rdata;
  end

  // read port and trim fields
  assign rdata_o = rdata;
  assign rc_osc_trim_o = trim;
  assign trim_range_bit_o = trim[scdiv_pkg::TRIM_RANGE_BIT];
  assign trim_fine_o = trim[scdiv_pkg::TRIM_RANGE_BIT-1:0];
  // timer osc pins only with rc source
  assign timer_osc_enable_o = rc_source_sel_i;
  assign timer_external_clock_select_o = ext_clk_sel && rc_source_sel_i;
endmodule : scdiv_top

// ===== verif/scdiv_top_asserts.sv
`timescale 1ns/1ps
// port-level watch on the divider and trim outputs
module scdiv_asserts #(
  parameter logic [7:0] FACTORY_TRIM = 8'h80
) (
  input wire logic sys_clk_i, // source clock
  input wire logic reset_i, // async reset
  input wire logic divide_by_eight_fuse_i, // fuse
  input wire logic rc_source_sel_i, // rc source
  input wire logic sys_clk_en_o, // tick
  input wire logic [3:0] divide_select_o, // code
  input wire logic [7:0] rc_osc_trim_o, // trim
  input wire logic trim_range_bit_o, // range
  input wire logic [6:0] trim_fine_o, // fine
  input wire logic timer_osc_enable_o, // timer osc
  input wire logic timer_external_clock_select_o // ext clock
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  a_reset_load: assert property ($fell(reset_i) |=>
    divide_select_o == {2'h0, {2{divide_by_eight_fuse_i}}}
    && rc_osc_trim_o == FACTORY_TRIM) else $error("bad reset load");
  a_trim_split: assert property (
    {trim_range_bit_o, trim_fine_o} == rc_osc_trim_o)
    else $error("trim split wrong");
  a_timer_osc: assert property (
    timer_osc_enable_o == rc_source_sel_i) else $error("timer osc bad");
  a_ext_gate: assert property (!rc_source_sel_i |->
    !timer_external_clock_select_o) else $error("ext clock ungated");
  a_div_one: assert property (divide_select_o == 4'h0 |->
    sys_clk_en_o) else $error("missing tick at divide one");
  // back to back ticks only at one
  a_tick_pair: assert property (sys_clk_en_o ##1 sys_clk_en_o |->
    divide_select_o == 4'h0) else $error("tick too fast");
  // switch only right after a tick
  a_sel_at_tick: assert property ($changed(divide_select_o) |->
    $past(sys_clk_en_o)) else $error("switch off tick");
  // divided clock ticks within a full period
  a_tick_bound: assert property (sys_clk_en_o |->
    ##[1:256] sys_clk_en_o) else $error("tick missing");
  c_div_max: cover property (divide_select_o == 4'h8);
  c_sel_change: cover property ($changed(divide_select_o));
  c_ext_on: cover property (timer_external_clock_select_o);
endmodule : scdiv_asserts

bind scdiv_top scdiv_asserts #(.FACTORY_TRIM(FACTORY_TRIM)) u_chk (
  .sys_clk_i, .reset_i, .divide_by_eight_fuse_i, .rc_source_sel_i,
  .sys_clk_en_o, .divide_select_o, .rc_osc_trim_o, .trim_range_bit_o,
  .trim_fine_o, .timer_osc_enable_o, .timer_external_clock_select_o);

// ===== verif/scdiv_top_tb.sv
`timescale 1ns/1ps
module scdiv_top_tb;
  localparam logic [7:0] TRIM = 8'h5A; // arbitrary factory value
  logic clk = 0, rst = 1, fuse = 1, rc = 1, wr = 0, rd = 0, rd_d = 0;
  logic en, ext, rng, tosc;
  logic [6:0] fine;
  logic [7:0] addr = 8'h00, wd = 8'h00, rdata, trim, d, e_v;
  logic [3:0] sel;
  logic [7:0] exp_q[$];
  int mismatches = 0, compares = 0, seed = 82, n;
  `define CHK(nm, e, a) begin compares++; if ((a) !== (e)) begin \
    mismatches++; $display("ERROR %s exp %h got %h", nm, e, a); end end
  scdiv_top #(.FACTORY_TRIM(TRIM)) u_dut (.sys_clk_i(clk), .reset_i(rst),
    .divide_by_eight_fuse_i(fuse), .rc_source_sel_i(rc), .addr_i(addr),
    .wdata_i(wd), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .sys_clk_en_o(en), .divide_select_o(sel), .rc_osc_trim_o(trim),
    .trim_range_bit_o(rng), .trim_fine_o(fine), .timer_osc_enable_o(tosc),
    .timer_external_clock_select_o(ext));
  always #2.5 clk = ~clk;
  // read data stands only in the cycle after the strobe
  always @(posedge clk)
  begin
    if (rd_d)
    begin
      e_v = exp_q.pop_front();
      `CHK("rdata", e_v, rdata)
    end
    rd_d <= rd;
  end
  // one bus cycle; strobes stay up if the next call follows
  task automatic op(input logic w, input logic [7:0] a, dv);
    wr <= w;
    rd <= !w;
    addr <= a;
    wd <= dv;
    @(posedge clk);
  endtask : op
  task automatic rreg(input logic [7:0] a, ev);
    exp_q.push_back(ev);
    op(0, a, 8'($random(seed)));
  endtask : rreg
  task automatic idle(input int k);
    wr <= 0;
    rd <= 0;
    repeat (k) @(posedge clk);
  endtask : idle
  task automatic give_verdict;
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : give_verdict
  // unlock, select, then measure the tick spacing
  task automatic setsel(input logic [3:0] c);
    op(1, 8'h04, 8'h80);
    op(1, 8'h04, {4'h0, c});
    rreg(8'h04, {4'h0, c});
    idle(1);
    repeat (600) if (sel !== c) @(negedge clk);
    `CHK("sel", c, sel)
    repeat (600) if (en !== 1'b1) @(negedge clk);
    @(negedge clk);
    n = 1;
    repeat (600)
      if (en !== 1'b1)
      begin
        @(negedge clk);
        n++;
      end
    `CHK("period", (c > 4'h8) ? 256 : 1 << c, n)
    @(posedge clk);
  endtask : setsel
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 0;
    idle(2);
    rreg(8'h04, 8'h03);
    rreg(8'h00, TRIM);
    // locked and malformed writes leave the select alone
    op(1, 8'h04, 8'h02);
    op(1, 8'h04, 8'h81);
    op(1, 8'h04, 8'h01);
    rreg(8'h04, 8'h03);
    for (int i = 9; i >= 0; i--) setsel((i == 9) ? 4'hF : 4'(i));
    // second unlock inside the open window must not extend it
    op(1, 8'h04, 8'h80);
    idle(2);
    op(1, 8'h04, 8'h80);
    idle(2);
    op(1, 8'h04, 8'h06);
    rreg(8'h04, 8'h00);
    // repeated unlock keeps it open; a select closes it
    op(1, 8'h04, 8'h80);
    op(1, 8'h04, 8'h80);
    op(1, 8'h04, 8'h06);
    op(1, 8'h04, 8'h02);
    rreg(8'h04, 8'h06);
    // no flash writes run, so any trim is allowed
    for (int j = 0; j < 4; j++)
    begin
      d = (j == 0) ? 8'h7F : (j == 1) ? 8'h80 : 8'($random(seed));
      op(1, 8'h00, d);
      rreg(8'h00, d);
      idle(1);
      `CHK("trim", d, trim)
      `CHK("range", d[7], rng)
      `CHK("fine", d[6:0], fine)
    end
    // unmapped place, then the timer clock select
    op(1, 8'h0C, 8'hFF);
    rreg(8'h0C, 8'h00);
    op(1, 8'h08, 8'h02);
    rreg(8'h08, 8'h03);
    idle(1);
    `CHK("ext", 1'b1, ext)
    `CHK("tosc", 1'b1, tosc)
    rc <= 0;
    rreg(8'h08, 8'h02);
    idle(1);
    `CHK("ext", 1'b0, ext)
    `CHK("tosc", 1'b0, tosc)
    // mid-run reset with the fuse unprogrammed
    fuse <= 0;
    rst <= 1;
    idle(3);
    rst <= 0;
    idle(2);
    rreg(8'h04, 8'h00);
    idle(3);
    give_verdict();
  end
  // hang guard well past the longest expected run
  initial
  begin
    #300000;
    mismatches++;
    give_verdict();
  end
endmodule : scdiv_top_tb
